//--- pkg/hsu_pkg.sv
// Shared constants, types and the state record of the host serial port.
// Assumes one 100 MHz system clock; the 27.12 MHz reference is made from it.
package hsu_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // Register locations inside the device map
  localparam logic [ADDR_W-1:0] BAUD_DIV_ADDR = 6'h1f;
  localparam logic [ADDR_W-1:0] TEST_PIN_CFG_ADDR = 6'h33;
  localparam logic [DATA_W-1:0] BAUD_DIV_RST = 8'heb;
  localparam logic [DATA_W-1:0] TEST_PIN_CFG_RST = 8'h80;
  localparam int LINE_EN_BIT = 7;

  // Address byte layout
  localparam int DIR_BIT = 7;
  localparam int SPI_ADDR_MSB = 6;
  localparam int SPI_ADDR_LSB = 1;
  localparam int UART_ADDR_MSB = 5;
  localparam int UART_ADDR_LSB = 0;

  // Baud divider fields and arithmetic
  localparam int EXP_MSB = 7;
  localparam int EXP_LSB = 5;
  localparam int MANT_MSB = 4;
  localparam int MANT_LSB = 0;
  localparam int DIV_W = 13;
  localparam logic [DIV_W-1:0] MANT_OFFSET = 13'h0021;
  localparam logic [DIV_W-1:0] DIV_ONE = 13'h0001;

  // Reference clock synthesis, in kHz
  localparam int SYS_KHZ = 100000;
  localparam int REF_KHZ = 27120;
  localparam int ACC_W = 17;

  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;

  typedef enum logic [1:0] {IF_DETECT, IF_I2C, IF_UART, IF_SPI} hsu_if_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} hsu_rx_e;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} hsu_tx_e;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } hsu_ram_req_s;

  typedef struct packed {
    logic o;
    logic oe;
  } hsu_pin_s;

  typedef struct packed {
    hsu_if_e mode;
    logic sck_q;
    logic rx_q;
    logic [BIT_CNT_W-1:0] spi_bit;
    logic spi_first;
    logic spi_read;
    logic [ADDR_W-1:0] spi_addr;
    logic [DATA_W-1:0] spi_rsh;
    logic [DATA_W-1:0] spi_tsh;
    logic [ACC_W-1:0] acc;
    logic ref_tick;
    hsu_rx_e rx_st;
    logic [DIV_W-1:0] rx_cnt;
    logic [BIT_CNT_W-1:0] rx_bit;
    logic [DATA_W-1:0] rx_sh;
    hsu_tx_e tx_st;
    logic [DIV_W-1:0] tx_cnt;
    logic [BIT_CNT_W-1:0] tx_bit;
    logic [DATA_W-1:0] tx_sh;
    logic tx_line;
    logic tx_pend;
    logic [DATA_W-1:0] tx_byte;
    logic u_wait_data;
    logic [ADDR_W-1:0] u_addr;
    logic [DATA_W-1:0] baud_div;
    logic [DATA_W-1:0] tpc;
    hsu_ram_req_s ram_req;
    logic [1:0] rd_stage;
    logic rd_uart0;
    logic rd_uart1;
    logic [ADDR_W-1:0] rd_addr0;
    logic [ADDR_W-1:0] rd_addr1;
    hsu_pin_s d7;
    hsu_pin_s d6;
    hsu_pin_s d5;
  } hsu_state_s;

endpackage

//--- logic/hsu_reg_ram.sv
// Register bank behind the host port: 64 bytes, one write or read per cycle.
// Assumes the caller holds the request for one cycle; read data come one edge later.
`timescale 1ns/10ps
module hsu_reg_ram
(
  input wire logic i_clk_sys,
  input wire hsu_pkg::hsu_ram_req_s i_req,
  output logic [hsu_pkg::DATA_W-1:0] o_rdata
);
  logic [hsu_pkg::DATA_W-1:0] mem [0:(1<<hsu_pkg::ADDR_W)-1];

  // No reset on the array; contents are undefined until written
  always_ff @(posedge i_clk_sys)
  begin
    if (i_req.we)
    begin
      mem[i_req.addr] <= i_req.wdata;
    end
    o_rdata <= mem[i_req.addr];
  end
endmodule // hsu_reg_ram

//--- logic/hsu_host_port.sv
// Host port: strap detection, SPI slave and UART register access.
// Assumes pins arrive synchronous to i_clk_sys and the host obeys the protocol limits.
`timescale 1ns/10ps

// What this block does
// - After reset, pick the host interface from the strap pin levels.
// - I2C pin high selects I2C; else address-select low UART, high SPI.
// - SPI slave: host drives clock and MOSI, device answers on MISO.
// - SPI bytes shift most significant bit first on both lines.
// - SPI data sampled on rising clock, changed only on falling clock.
// - MISO updates on falling clock edges, stable across the next rise.
// - SPI address byte: bit 7 direction, bits 6..1 address, bit 0 zero.
// - SPI read: each byte returns data for the previously sent address.
// - SPI write: one address byte then any number of data bytes.
// - SPI port works with host clocks up to 10 Mbit/s.
// - UART runs at 9.6 kBd after reset until the divider is written.
// - Divider register holds 3-bit exponent and 5-bit mantissa.
// - Exponent 0 divides by mantissa+1, else (mantissa+33) shifted by exponent-1.
// - Divider values give the tabulated rates within 1.5 percent.
// - UART character: start bit 0, eight data bits, stop bit 1.
// - UART bytes travel least significant bit first.
// - UART read: address byte in, one data byte returned.
// - Request and auxiliary outputs disabled when line drive enable is cleared.
// - UART address byte: bit 7 direction, bit 6 reserved, bits 5..0 address.
// - UART write echoes the address byte during the data byte slot.
module hsu_host_port
#(
  parameter int CLK_KHZ = hsu_pkg::SYS_KHZ,
  parameter int REF_KHZ = hsu_pkg::REF_KHZ
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_pin_i2c,
  input wire logic i_pin_ea,
  input wire logic i_pin_sda,
  input wire logic i_pin_d5,
  input wire logic i_pin_d6,
  input wire logic i_pin_d7,
  output logic o_d5,
  output logic o_d5_oe,
  output logic o_d6,
  output logic o_d6_oe,
  output logic o_d7,
  output logic o_d7_oe,
  output hsu_pkg::hsu_if_e o_if_mode
);
  localparam logic [hsu_pkg::ACC_W-1:0] ACC_STEP = hsu_pkg::ACC_W'(REF_KHZ);
  localparam logic [hsu_pkg::ACC_W-1:0] ACC_WRAP = hsu_pkg::ACC_W'(CLK_KHZ);

  logic [1:0] rst_sync_ff;
  logic rst_n;
  hsu_pkg::hsu_state_s state_ff;
  hsu_pkg::hsu_state_s nxt_state;
  logic [hsu_pkg::DATA_W-1:0] ram_rdata;
  logic [hsu_pkg::DATA_W-1:0] rd_data;
  logic [hsu_pkg::DATA_W-1:0] spi_byte;
  logic [hsu_pkg::DIV_W-1:0] div_full;
  logic [hsu_pkg::DIV_W-1:0] div_half;
  logic sck_rise;
  logic sck_fall;
  logic wr_baud;

  function automatic hsu_pkg::hsu_if_e pick_mode(input logic i2c, input logic ea);
    if (i2c)
      return hsu_pkg::IF_I2C;
    else if (ea)
      return hsu_pkg::IF_SPI;
    else
      return hsu_pkg::IF_UART;
  endfunction

  // Bit time in 27.12 MHz reference ticks
  function automatic logic [hsu_pkg::DIV_W-1:0] baud_ticks(input logic [hsu_pkg::DATA_W-1:0] v);
    logic [2:0] e;
    logic [hsu_pkg::DIV_W-1:0] m;
    e = v[hsu_pkg::EXP_MSB:hsu_pkg::EXP_LSB];
    m = hsu_pkg::DIV_W'(v[hsu_pkg::MANT_MSB:hsu_pkg::MANT_LSB]);
    if (e == 3'h0)
      return m + hsu_pkg::DIV_ONE;
    else
      return (m + hsu_pkg::MANT_OFFSET) << (e - 3'h1);
  endfunction

  // Control registers live in flops because they steer logic; the rest go to the bank
  function automatic hsu_pkg::hsu_state_s do_write(input hsu_pkg::hsu_state_s s,
                                                   input logic [hsu_pkg::ADDR_W-1:0] a,
                                                   input logic [hsu_pkg::DATA_W-1:0] d);
    hsu_pkg::hsu_state_s r;
    r = s;
    if (a == hsu_pkg::BAUD_DIV_ADDR)
      r.baud_div = d;
    else if (a == hsu_pkg::TEST_PIN_CFG_ADDR)
      r.tpc = d;
    else
    begin
      r.ram_req.we = 1'b1;
      r.ram_req.addr = a;
      r.ram_req.wdata = d;
    end
    return r;
  endfunction

  function automatic hsu_pkg::hsu_state_s do_read(input hsu_pkg::hsu_state_s s,
                                                  input logic [hsu_pkg::ADDR_W-1:0] a,
                                                  input logic for_uart);
    hsu_pkg::hsu_state_s r;
    r = s;
    r.ram_req.addr = a;
    r.rd_addr0 = a;
    r.rd_uart0 = for_uart;
    r.rd_stage[0] = 1'b1;
    return r;
  endfunction

  // Reset release through two flops
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_sync_ff <= 2'b00;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  hsu_reg_ram u_ram
  (
    .i_clk_sys(i_clk_sys),
    .i_req(state_ff.ram_req),
    .o_rdata(ram_rdata)
  );

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.ram_req.we = 1'b0;
    nxt_state.rd_stage = {state_ff.rd_stage[0], 1'b0};
    nxt_state.rd_uart1 = state_ff.rd_uart0;
    nxt_state.rd_addr1 = state_ff.rd_addr0;
    nxt_state.sck_q = i_pin_d5;
    nxt_state.rx_q = i_pin_sda;
    sck_rise = !state_ff.sck_q && i_pin_d5;
    sck_fall = state_ff.sck_q && !i_pin_d5;
    spi_byte = {state_ff.spi_rsh[6:0], i_pin_d6};
    div_full = baud_ticks(state_ff.baud_div);
    div_half = (div_full > hsu_pkg::DIV_ONE) ? (div_full >> 1) : hsu_pkg::DIV_ONE;
    if (state_ff.rd_addr1 == hsu_pkg::BAUD_DIV_ADDR)
      rd_data = state_ff.baud_div;
    else if (state_ff.rd_addr1 == hsu_pkg::TEST_PIN_CFG_ADDR)
      rd_data = state_ff.tpc;
    else
      rd_data = ram_rdata;
    // 27.12 MHz tick by phase accumulation: jitter of one system cycle per tick
    if (state_ff.acc + ACC_STEP >= ACC_WRAP)
    begin
      nxt_state.acc = state_ff.acc + ACC_STEP - ACC_WRAP;
      nxt_state.ref_tick = 1'b1;
    end
    else
    begin
      nxt_state.acc = state_ff.acc + ACC_STEP;
      nxt_state.ref_tick = 1'b0;
    end
    // Straps are read once; afterwards the choice is frozen
    if (state_ff.mode == hsu_pkg::IF_DETECT)
      nxt_state.mode = pick_mode(i_pin_i2c, i_pin_ea);
    nxt_state.d7 = '{o: 1'b0, oe: 1'b0};
    nxt_state.d6 = '{o: 1'b0, oe: 1'b0};
    nxt_state.d5 = '{o: 1'b0, oe: 1'b0};
    unique case (state_ff.mode)
      hsu_pkg::IF_DETECT, hsu_pkg::IF_I2C:
      begin
        // I2C protocol handling sits outside this port; all drivers stay off
      end
      hsu_pkg::IF_SPI:
      begin
        nxt_state.d7.o = state_ff.d7.o;
        if (i_pin_sda)
        begin
          nxt_state.spi_bit = '0;
          nxt_state.spi_first = 1'b1;
        end
        else
        begin
          nxt_state.d7.oe = 1'b1;
          if (sck_rise)
          begin
            nxt_state.spi_rsh = spi_byte;
            nxt_state.spi_bit = state_ff.spi_bit + 3'h1;
            if (state_ff.spi_bit == hsu_pkg::LAST_BIT)
            begin
              if (state_ff.spi_first)
              begin
                nxt_state.spi_first = 1'b0;
                nxt_state.spi_read = spi_byte[hsu_pkg::DIR_BIT];
                nxt_state.spi_addr = spi_byte[hsu_pkg::SPI_ADDR_MSB:hsu_pkg::SPI_ADDR_LSB];
                if (spi_byte[hsu_pkg::DIR_BIT])
                  nxt_state = do_read(nxt_state, spi_byte[hsu_pkg::SPI_ADDR_MSB:hsu_pkg::SPI_ADDR_LSB], 1'b0);
              end
              else if (state_ff.spi_read)
              begin
                // A zero byte only closes the burst and fetches nothing
                if (spi_byte != '0)
                  nxt_state = do_read(nxt_state, spi_byte[hsu_pkg::SPI_ADDR_MSB:hsu_pkg::SPI_ADDR_LSB], 1'b0);
              end
              else
                nxt_state = do_write(nxt_state, state_ff.spi_addr, spi_byte);
            end
          end
          if (sck_fall)
          begin
            nxt_state.d7.o = state_ff.spi_tsh[hsu_pkg::DATA_W-1];
            nxt_state.spi_tsh = {state_ff.spi_tsh[6:0], 1'b0};
          end
        end
        // Read data land three cycles after the last rise, before the next fall at 10 Mbit/s
        if (state_ff.rd_stage[1] && !state_ff.rd_uart1)
          nxt_state.spi_tsh = rd_data;
      end
      hsu_pkg::IF_UART:
      begin
        nxt_state.d7 = '{o: state_ff.tx_line, oe: 1'b1};
        nxt_state.d5 = '{o: state_ff.tx_pend || (state_ff.tx_st != hsu_pkg::TX_IDLE),
                         oe: state_ff.tpc[hsu_pkg::LINE_EN_BIT]};
        nxt_state.d6 = '{o: state_ff.u_wait_data, oe: state_ff.tpc[hsu_pkg::LINE_EN_BIT]};
        // Taking a queued byte clears the flag first, so a request landing in the same cycle still sets it
        if (state_ff.tx_st == hsu_pkg::TX_IDLE && state_ff.tx_pend)
          nxt_state.tx_pend = 1'b0;
        unique case (state_ff.rx_st)
          hsu_pkg::RX_IDLE:
            if (state_ff.rx_q && !i_pin_sda)
            begin
              nxt_state.rx_st = hsu_pkg::RX_START;
              nxt_state.rx_cnt = div_half;
            end
          hsu_pkg::RX_START:
            if (state_ff.ref_tick)
            begin
              nxt_state.rx_cnt = state_ff.rx_cnt - hsu_pkg::DIV_ONE;
              if (state_ff.rx_cnt == hsu_pkg::DIV_ONE)
              begin
                nxt_state.rx_st = i_pin_sda ? hsu_pkg::RX_IDLE : hsu_pkg::RX_DATA;
                nxt_state.rx_cnt = div_full;
                nxt_state.rx_bit = '0;
              end
            end
          hsu_pkg::RX_DATA:
            if (state_ff.ref_tick)
            begin
              nxt_state.rx_cnt = state_ff.rx_cnt - hsu_pkg::DIV_ONE;
              if (state_ff.rx_cnt == hsu_pkg::DIV_ONE)
              begin
                nxt_state.rx_sh = {i_pin_sda, state_ff.rx_sh[7:1]};
                nxt_state.rx_cnt = div_full;
                nxt_state.rx_bit = state_ff.rx_bit + 3'h1;
                if (state_ff.rx_bit == hsu_pkg::LAST_BIT)
                  nxt_state.rx_st = hsu_pkg::RX_STOP;
              end
            end
          hsu_pkg::RX_STOP:
            if (state_ff.ref_tick)
            begin
              nxt_state.rx_cnt = state_ff.rx_cnt - hsu_pkg::DIV_ONE;
              if (state_ff.rx_cnt == hsu_pkg::DIV_ONE)
              begin
                nxt_state.rx_st = hsu_pkg::RX_IDLE;
                // A missing stop bit drops the character
                if (i_pin_sda)
                begin
                  if (state_ff.u_wait_data)
                  begin
                    nxt_state.u_wait_data = 1'b0;
                    nxt_state = do_write(nxt_state, state_ff.u_addr, state_ff.rx_sh);
                  end
                  else if (state_ff.rx_sh[hsu_pkg::DIR_BIT])
                    nxt_state = do_read(nxt_state, state_ff.rx_sh[hsu_pkg::UART_ADDR_MSB:hsu_pkg::UART_ADDR_LSB],
                                        1'b1);
                  else
                  begin
                    nxt_state.u_wait_data = 1'b1;
                    nxt_state.u_addr = state_ff.rx_sh[hsu_pkg::UART_ADDR_MSB:hsu_pkg::UART_ADDR_LSB];
                    nxt_state.tx_pend = 1'b1;
                    nxt_state.tx_byte = state_ff.rx_sh;
                  end
                end
              end
            end
        endcase
        if (state_ff.rd_stage[1] && state_ff.rd_uart1)
        begin
          nxt_state.tx_pend = 1'b1;
          nxt_state.tx_byte = rd_data;
        end
        unique case (state_ff.tx_st)
          hsu_pkg::TX_IDLE:
          begin
            nxt_state.tx_line = 1'b1;
            if (state_ff.tx_pend)
            begin
              nxt_state.tx_sh = state_ff.tx_byte;
              nxt_state.tx_st = hsu_pkg::TX_START;
              nxt_state.tx_line = 1'b0;
              nxt_state.tx_cnt = div_full;
            end
          end
          default:
            if (state_ff.ref_tick)
            begin
              nxt_state.tx_cnt = state_ff.tx_cnt - hsu_pkg::DIV_ONE;
              if (state_ff.tx_cnt == hsu_pkg::DIV_ONE)
              begin
                nxt_state.tx_cnt = div_full;
                if (state_ff.tx_st == hsu_pkg::TX_STOP)
                begin
                  nxt_state.tx_st = hsu_pkg::TX_IDLE;
                end
                else if (state_ff.tx_st == hsu_pkg::TX_DATA && state_ff.tx_bit == hsu_pkg::LAST_BIT)
                begin
                  nxt_state.tx_st = hsu_pkg::TX_STOP;
                  nxt_state.tx_line = 1'b1;
                end
                else
                begin
                  nxt_state.tx_bit = (state_ff.tx_st == hsu_pkg::TX_START) ? '0 : state_ff.tx_bit + 3'h1;
                  nxt_state.tx_st = hsu_pkg::TX_DATA;
                  nxt_state.tx_line = state_ff.tx_sh[0];
                  nxt_state.tx_sh = {1'b0, state_ff.tx_sh[7:1]};
                end
              end
            end
        endcase
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= '0;
      state_ff.mode <= hsu_pkg::IF_DETECT;
      state_ff.spi_first <= 1'b1;
      state_ff.rx_q <= 1'b1;
      state_ff.tx_line <= 1'b1;
      state_ff.baud_div <= hsu_pkg::BAUD_DIV_RST;
      state_ff.tpc <= hsu_pkg::TEST_PIN_CFG_RST;
    end
    else
      state_ff <= nxt_state;
  end

  assign o_d5 = state_ff.d5.o;
  assign o_d5_oe = state_ff.d5.oe;
  assign o_d6 = state_ff.d6.o;
  assign o_d6_oe = state_ff.d6.oe;
  assign o_d7 = state_ff.d7.o;
  assign o_d7_oe = state_ff.d7.oe;
  assign o_if_mode = state_ff.mode;

  // Decoded apart from the write path, so the hold check does not restate the logic it guards
  assign wr_baud = (state_ff.mode == hsu_pkg::IF_SPI && !i_pin_sda && sck_rise && !state_ff.spi_first
                    && !state_ff.spi_read && state_ff.spi_bit == hsu_pkg::LAST_BIT
                    && state_ff.spi_addr == hsu_pkg::BAUD_DIV_ADDR)
                || (state_ff.mode == hsu_pkg::IF_UART && state_ff.rx_st == hsu_pkg::RX_STOP && state_ff.ref_tick
                    && state_ff.rx_cnt == hsu_pkg::DIV_ONE && i_pin_sda && state_ff.u_wait_data
                    && state_ff.u_addr == hsu_pkg::BAUD_DIV_ADDR);

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_mode_frozen: assert property ((state_ff.mode != hsu_pkg::IF_DETECT) |=> $stable(state_ff.mode))
    else $error("interface mode changed after detection");
  a_mode_strap: assert property ((state_ff.mode == hsu_pkg::IF_DETECT)
                                 |=> (state_ff.mode == pick_mode($past(i_pin_i2c), $past(i_pin_ea))))
    else $error("detected mode does not match straps");
  a_miso_on_fall: assert property ((state_ff.mode == hsu_pkg::IF_SPI && $changed(o_d7) && $past(o_d7_oe) && o_d7_oe)
                                   |-> $past(state_ff.sck_q) && !state_ff.sck_q)
    else $error("miso changed without a falling clock");
  a_spi_msb_in: assert property ((state_ff.mode == hsu_pkg::IF_SPI && !i_pin_sda && !state_ff.sck_q && i_pin_d5)
                                 |=> state_ff.spi_rsh[0] == $past(i_pin_d6))
    else $error("mosi bit not shifted in at the low end");
  a_baud_hold: assert property (!wr_baud |=> $stable(state_ff.baud_div))
    else $error("baud divider changed without a write");
  a_line_gate: assert property (!state_ff.tpc[hsu_pkg::LINE_EN_BIT] |=> !o_d5_oe && !o_d6_oe)
    else $error("request or aux output driven while disabled");
  a_tx_frame: assert property ((state_ff.tx_st == hsu_pkg::TX_IDLE && $past(state_ff.tx_st) == hsu_pkg::TX_STOP)
                               |-> state_ff.tx_line ##1 o_d7)
    else $error("uart stop bit not high");
  a_tx_start: assert property ((state_ff.tx_st == hsu_pkg::TX_START) |-> !state_ff.tx_line)
    else $error("uart start bit not low");
  a_tx_lsb: assert property ((state_ff.tx_st == hsu_pkg::TX_START ##1 state_ff.tx_st == hsu_pkg::TX_DATA)
                             |-> state_ff.tx_line == $past(state_ff.tx_sh[0]))
    else $error("uart data not sent lsb first");
  a_echo_write: assert property ((state_ff.mode == hsu_pkg::IF_UART && $rose(state_ff.u_wait_data))
                                 |-> state_ff.tx_pend && state_ff.tx_byte[hsu_pkg::DIR_BIT] == 1'b0)
    else $error("write address not queued for echo");
endmodule // hsu_host_port

//--- sim/hsu_host_model.sv
// Host side model: SPI master and UART host on the shared port pins.
// Assumes the bench calls one task per line at a time; clock is the system clock.
`timescale 1ns/10ps
module hsu_host_model
(
  input wire logic i_clk_sys,
  input wire logic i_line_in,
  output logic o_sel_rx,
  output logic o_sck,
  output logic o_mosi
);
  initial
  begin
    o_sel_rx = 1'b1;
    o_sck = 1'b0;
    o_mosi = 1'b0;
  end

  // Deselected MOSI toggles so a stale bit is never mistaken for data
  always @(posedge i_clk_sys)
    if (o_sel_rx)
      o_mosi <= ~o_mosi;

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  // Six cycles a phase keeps the serial clock below 10 Mbit/s
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      o_sck = 1'b0;
      o_mosi = tx[i];
      cyc(6);
      rx[i] = i_line_in;
      o_sck = 1'b1;
      cyc(6);
    end
  endtask

  task automatic spi_frame(input logic [7:0] txq[$], output logic [7:0] rxq[$]);
    logic [7:0] r;
    rxq = {};
    o_sel_rx = 1'b0;
    cyc(6);
    foreach (txq[k])
    begin
      spi_byte(txq[k], r);
      rxq.push_back(r);
    end
    o_sck = 1'b0;
    cyc(6);
    o_sel_rx = 1'b1;
    cyc(6);
  endtask

  task automatic uart_send(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      o_sel_rx = f[i];
      cyc(bt);
    end
  endtask

  task automatic uart_recv(input int bt, input int lim, output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (i_line_in !== 1'b0 && n < lim)
    begin
      cyc(1);
      n++;
    end
    cyc(bt / 2);
    ok = (n < lim) && (i_line_in === 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      cyc(bt);
      b[i] = i_line_in;
    end
    cyc(bt);
    ok = ok && (i_line_in === 1'b1);
  endtask
endmodule // hsu_host_model

//--- sim/hsu_host_port_tb_top.sv
// Testbench: straps each host interface in turn and runs register traffic.
// Assumes the host model drives the port pins and the design checks itself.
`timescale 1ns/10ps
module hsu_host_port_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic pin_i2c = 1'b0;
  logic pin_ea = 1'b1;
  logic sda, sck, mosi, d5, d5_oe, d6, d6_oe, d7, d7_oe;
  logic line_d7;
  hsu_pkg::hsu_if_e if_mode;
  int error_cnt = 0;
  int checks_done = 0;

  always #5 clk_sys = ~clk_sys;

  // A released data line reads inverted, so sampling it while undriven shows up
  assign line_d7 = d7_oe ? d7 : ~d7;

  // Reference equal to the system clock: one tick a cycle, bit times read in cycles
  hsu_host_port #(.CLK_KHZ(100000), .REF_KHZ(100000)) hsu_host_port_i (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
    .i_pin_i2c(pin_i2c), .i_pin_ea(pin_ea), .i_pin_sda(sda), .i_pin_d5(sck), .i_pin_d6(mosi), .i_pin_d7(line_d7),
    .o_d5(d5), .o_d5_oe(d5_oe), .o_d6(d6), .o_d6_oe(d6_oe), .o_d7(d7), .o_d7_oe(d7_oe), .o_if_mode(if_mode));

  hsu_host_model hsu_host_model_i (.i_clk_sys(clk_sys), .i_line_in(line_d7), .o_sel_rx(sda), .o_sck(sck),
    .o_mosi(mosi));

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic int bits(input logic [7:0] div);
    int m;
    m = int'(div[4:0]);
    return (div[7:5] == 3'h0) ? m + 1 : (m + 33) << (div[7:5] - 3'h1);
  endfunction

  task automatic restart(input logic i2c, input logic ea, input hsu_pkg::hsu_if_e exp);
    int n;
    rst_n = 1'b0;
    pin_i2c = i2c;
    pin_ea = ea;
    hsu_host_model_i.cyc(6);
    rst_n = 1'b1;
    n = 0;
    while (if_mode === hsu_pkg::IF_DETECT && n < 20)
    begin
      hsu_host_model_i.cyc(1);
      n++;
    end
    hsu_host_model_i.cyc(4);
    chk("if_mode", {6'h0, if_mode}, {6'h0, exp});
    if (n == 20)
      results();
  endtask

  task automatic uart_xfer(input logic [7:0] a, input logic [7:0] d, input logic wr, input int bt, input int lim,
    input logic [7:0] exp);
    logic [7:0] r;
    logic ok;
    fork
      begin
        hsu_host_model_i.uart_send(a, bt);
        chk("uart request aux", {6'h0, d5, d6}, {6'h0, 1'b1, wr});
        if (wr)
          hsu_host_model_i.uart_send(d, bt);
      end
      hsu_host_model_i.uart_recv(bt, lim, r, ok);
    join
    chk("uart frame", {7'h0, ok}, 8'h01);
    if (!ok)
      results();
    chk("uart byte", r, exp);
  endtask

  initial
  begin
    logic [7:0] q[$];
    restart(1'b0, 1'b1, hsu_pkg::IF_SPI);
    hsu_host_model_i.spi_frame({8'h0a, 8'ha5, 8'h3c}, q);
    hsu_host_model_i.spi_frame({8'h8a, 8'hbe, 8'he6, 8'h00}, q);
    chk("spi data 05", q[1], 8'h3c);
    chk("spi baud div", q[2], hsu_pkg::BAUD_DIV_RST);
    chk("spi test pins", q[3], hsu_pkg::TEST_PIN_CFG_RST);
    chk("miso oe idle", {7'h0, d7_oe}, 8'h00);
    $display("test spi done");
    restart(1'b1, 1'b0, hsu_pkg::IF_I2C);
    hsu_host_model_i.spi_frame({8'h0a, 8'h55}, q);
    chk("i2c oe", {5'h0, d5_oe, d6_oe, d7_oe}, 8'h00);
    $display("test i2c done");
    restart(1'b0, 1'b0, hsu_pkg::IF_UART);
    chk("uart oe", {5'h0, d5_oe, d6_oe, d7_oe}, 8'h07);
    // Fastest rate the host may use is 1228.8 kBd
    uart_xfer(8'h1f, 8'h15, 1'b1, bits(hsu_pkg::BAUD_DIV_RST), 40000, 8'h1f);
    hsu_host_model_i.cyc(10);
    uart_xfer(8'h9f, 8'h00, 1'b0, bits(8'h15), 400, 8'h15);
    uart_xfer(8'h33, 8'h00, 1'b1, bits(8'h15), 400, 8'h33);
    hsu_host_model_i.cyc(30);
    chk("uart oe off", {6'h0, d5_oe, d6_oe}, 8'h00);
    $display("test uart done");
    results();
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    results();
  end
endmodule // hsu_host_port_tb_top
